// file: core/pmseq_pkg.sv
package pmseq_pkg;
    // ----------------
    // Sizes and timing
    // ----------------
    localparam int          NUM_OUT        = 5;
    localparam int          NUM_BUCK       = 3;
    localparam int          BUCK2_IDX      = 1;
    localparam int          CNT_W          = 24;
    localparam int          CLK_MHZ        = 50;
    localparam int          DELAY_STEP_US  = 1000;
    localparam int          DELAY_STEP_CYC = DELAY_STEP_US * CLK_MHZ;
    localparam int          SS_STEP_US     = 200;
    localparam int          SS_STEP_CYC    = SS_STEP_US * CLK_MHZ;

    // ----------------
    // Register offsets
    // ----------------
    localparam logic [7:0]  ADDR_INMON     = 8'h00;
    localparam logic [7:0]  ADDR_OUT_BASE  = 8'h10;
    localparam logic [7:0]  OUT_STRIDE     = 8'h04;
    localparam logic [7:0]  ADDR_SEC_BASE  = 8'h30;
    localparam logic [7:0]  ADDR_CTRL      = 8'h40;
    localparam logic [7:0]  ADDR_FMASK     = 8'h41;
    localparam logic [7:0]  ADDR_FAULT     = 8'h42;
    localparam logic [7:0]  ADDR_FFLAG     = 8'h43;
    localparam logic [7:0]  ADDR_SUPLVL    = 8'h44;
    localparam logic [7:0]  ADDR_WARNLVL   = 8'h45;
    localparam logic [7:0]  ADDR_KEEP      = 8'h46;
    localparam logic [7:0]  ADDR_MISC      = 8'h47;

    // Fields within a per-output block
    localparam logic [1:0]  FLD_TRIG       = 2'h0;
    localparam logic [1:0]  FLD_DELAY      = 2'h1;
    localparam logic [1:0]  FLD_SS         = 2'h2;
    localparam logic [1:0]  FLD_VSET       = 2'h3;

    // Bit positions
    localparam int          INMON_SUP_LAT  = 0;
    localparam int          INMON_WARN_LAT = 1;
    localparam int          INMON_SUP_LIVE = 2;
    localparam int          INMON_WARN_LIVE = 3;
    localparam int          CTRL_SLEEP     = 0;
    localparam int          CTRL_OFF       = 1;
    localparam int          CTRL_SCAL_LO   = 4;
    localparam int          MISC_STRAP_POL = 0;
    localparam int          MISC_B2_SLP_SEC = 1;

    // Trigger codes; 1..5 select power_good of output code-1
    localparam logic [2:0]  TRIG_INPUT_GOOD = 3'h0;
    localparam logic [2:0]  TRIG_GPIO      = 3'h6;

    // Supervisor level codes, 100 mV per code above 2.7 V
    localparam logic [4:0]  SUP_LVL_MAX    = 5'h15;
    localparam logic [4:0]  WARN_LVL_MAX   = 5'h1E;

    // Reset values
    localparam logic [2:0]  RST_TRIG       = 3'h0;
    localparam logic [3:0]  RST_ON_DLY     = 4'h1;
    localparam logic [3:0]  RST_OFF_DLY    = 4'h1;
    localparam logic [1:0]  RST_SS         = 2'h1;
    localparam logic [7:0]  RST_VSET0      = 8'h40;
    localparam logic [7:0]  RST_VSET1      = 8'h30;
    localparam logic [4:0]  RST_SUPLVL     = 5'h03;
    localparam logic [4:0]  RST_WARNLVL    = 5'h06;
    localparam logic [4:0]  RST_FMASK      = 5'h1F;
    localparam logic [4:0]  RST_KEEP       = 5'h00;

    // ----------------
    // Types
    // ----------------
    typedef enum logic [4:0] {
        ST_OFF      = 5'h01,
        ST_ON_WAIT  = 5'h02,
        ST_RAMP     = 5'h04,
        ST_ON       = 5'h08,
        ST_OFF_WAIT = 5'h10
    } pmseq_state_type;

    typedef struct packed {
        logic       tsd;
        logic       twarn;
        logic       ilim;
        logic       uv;
        logic       ov;
    } pmseq_fault_type;

    typedef struct packed {
        logic [2:0] trig;
        logic [3:0] on_dly;
        logic [3:0] off_dly;
        logic [1:0] ss;
        logic [7:0] vset0;
    } pmseq_cfg_type;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } pmseq_req_type;
endpackage

// file: core/pmseq_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Each of five outputs keeps trigger, on delay, off delay, soft-start, voltage.
// - Output turns on from another power good, input good, or GPIO.
// - After trigger goes active, wait programmed on delay before ramping.
// - On sleep request, wait each output's off delay before switching off.
// - Delay, soft-start, voltage settings writable; defaults return on reset.
// - Soft-start setting times each output's ramp, one field per output.
// - Power up automatic or by GPIO, latched or level; off by GPIO or command.
// - Buck2 uses primary normally; secondary in scaling, sleep or GPIO, live.
// - Buck1 and buck3 never change voltage selection while running.
// - Strap picks buck1/3 setting, polarity selectable, frozen while running.
// - Scaling by host needs factory enable and nonzero scaling select.
// - Scaling changes only voltage, never the operating state.
// - Input-good-triggered outputs stay off until input reaches the programmable supervisor level.
// - Later drop below supervisor level leaves outputs running.
// - Active-low supervisor pin copy and live status bit.
// - Below supervisor level latches interrupt unless masked, cleared by read.
// - Second warning level with active-low pin copy and live status bit.
// - Below warning level latches maskable interrupt, cleared by read.
// - Live fault flags readable regardless of masking.
// - Unmasked fault sets fault bit; interrupt releases after clear and read.
// - Sleep entry and exit obey each output's own delays.
module pmseq_top
    import pmseq_pkg::*;
#(
    parameter int          DELAY_STEP    = DELAY_STEP_CYC,
    parameter int          SS_STEP       = SS_STEP_CYC,
    parameter bit          AUTO_START    = 1'b1,
    parameter bit          GPIO_LATCH    = 1'b1,
    parameter bit          SCAL_HOST_EN  = 1'b1,
    parameter bit          SUP_IRQ_MASK  = 1'b0,
    parameter bit          WARN_IRQ_MASK = 1'b0
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        resetn,
    // Register access
    input  wire pmseq_req_type               req,
    output logic [7:0]                       reg_rdata,
    // Analog status
    input  wire logic [5:0]                  vin_code,
    input  wire logic [NUM_OUT-1:0]          power_good,
    input  wire pmseq_fault_type             fault_cond,
    // GPIO inputs
    input  wire logic                        power_on_gpio,
    input  wire logic                        seq_gpio,
    input  wire logic                        sleep_gpio,
    input  wire logic                        scaling_gpio,
    input  wire logic                        strap_gpio,
    // Regulator control
    output logic [NUM_OUT-1:0]               out_enable,
    output logic [NUM_OUT-1:0]               out_ramping,
    output logic [NUM_OUT-1:0][7:0]          out_vset,
    output logic                             buck2_secondary,
    // Host signals
    output logic                             supervisor_low_n,
    output logic                             warning_low_n,
    output logic                             interrupt_out_n
);

    // ----------------
    // Helpers
    // ----------------
    function automatic logic [CNT_W-1:0] scaled(input logic [3:0] code, input int unit);
        scaled = CNT_W'(int'(code) * unit);
    endfunction

    function automatic logic trig_active(input logic [2:0] sel, input logic in_good,
                                         input logic [NUM_OUT-1:0] pg, input logic gp);
        if (sel == TRIG_INPUT_GOOD) begin
            trig_active = in_good;
        end else if (sel == TRIG_GPIO) begin
            trig_active = gp;
        end else if (int'(sel) <= NUM_OUT) begin
            trig_active = pg[sel - 3'h1];
        end else begin
            trig_active = 1'b0;
        end
    endfunction

    // ----------------
    // Register state
    // ----------------
    pmseq_cfg_type              cfg [NUM_OUT];
    logic [7:0]                 vset1 [NUM_BUCK];
    logic                       sleep_bit;
    logic                       off_cmd;
    logic [2:0]                 scaling_select_field;
    logic [4:0]                 fault_mask;
    logic [4:0]                 fault_bits;
    logic [4:0]                 input_supervisor_level;
    logic [4:0]                 input_low_warning;
    logic [NUM_OUT-1:0]         sleep_keep;
    logic                       strap_pol;
    logic                       b2_sleep_sec;
    logic                       sup_latched;
    logic                       warn_latched;
    logic                       input_good_seen;
    logic                       dev_on;
    logic                       gpio_prev;
    logic                       strap_sel [NUM_BUCK];

    // ----------------
    // Address decode
    // ----------------
    wire logic [7:0]  out_off   = req.addr - ADDR_OUT_BASE;
    wire logic        out_hit   = (req.addr >= ADDR_OUT_BASE) &&
                                  (out_off < 8'(NUM_OUT * int'(OUT_STRIDE)));
    wire logic [2:0]  out_idx   = out_off[4:2];
    wire logic [1:0]  out_fld   = out_off[1:0];
    wire logic [7:0]  sec_off   = req.addr - ADDR_SEC_BASE;
    wire logic        sec_hit   = (req.addr >= ADDR_SEC_BASE) && (sec_off < 8'(NUM_BUCK));
    wire logic        rd_inmon  = req.rd && (req.addr == ADDR_INMON);
    wire logic        rd_fault  = req.rd && (req.addr == ADDR_FAULT);
    wire logic [4:0]  wr_lvl    = req.wdata[4:0];

    // ----------------
    // Supervisor and warning comparisons
    // ----------------
    wire logic        sup_below  = vin_code < {1'b0, input_supervisor_level};
    wire logic        warn_below = vin_code < {1'b0, input_low_warning};
    wire logic [4:0]  fault_now  = fault_cond;
    wire logic        next_sup_latched  = (sup_below & ~SUP_IRQ_MASK) |
                                          (sup_latched & ~rd_inmon);
    wire logic        next_warn_latched = (warn_below & ~WARN_IRQ_MASK) |
                                          (warn_latched & ~rd_inmon);
    wire logic [4:0]  next_fault_bits   = (fault_now & ~fault_mask) |
                                          (fault_bits & ~({5{rd_fault}} & ~fault_now));
    wire logic        next_irq_n = ~(|next_fault_bits | next_sup_latched | next_warn_latched);

    // ----------------
    // Power-on control and low-power request
    // ----------------
    wire logic        gpio_rise  = power_on_gpio & ~gpio_prev;
    wire logic        next_dev_on = off_cmd ? 1'b0 :
                                    AUTO_START ? 1'b1 :
                                    GPIO_LATCH ? (dev_on | gpio_rise) : power_on_gpio;
    wire logic        low_power  = sleep_bit | sleep_gpio;
    wire logic        scal_host  = SCAL_HOST_EN && (scaling_select_field != 3'h0);
    wire logic        next_b2_sec = scal_host | scaling_gpio |
                                    (low_power & b2_sleep_sec);

    // ----------------
    // Read data
    // ----------------
    pmseq_cfg_type    rd_cfg;
    assign rd_cfg = cfg[out_idx];
    wire logic [7:0]  rd_out = (out_fld == FLD_TRIG)  ? {5'h00, rd_cfg.trig} :
                               (out_fld == FLD_DELAY) ? {rd_cfg.off_dly, rd_cfg.on_dly} :
                               (out_fld == FLD_SS)    ? {6'h00, rd_cfg.ss} : rd_cfg.vset0;
    wire logic [7:0]  next_rdata =
        (req.addr == ADDR_INMON)   ? {4'h0, ~warn_below, ~sup_below,
                                      warn_latched, sup_latched} :
        out_hit                    ? rd_out :
        sec_hit                    ? vset1[sec_off[1:0]] :
        (req.addr == ADDR_CTRL)    ? {1'b0, scaling_select_field, 2'h0, off_cmd, sleep_bit} :
        (req.addr == ADDR_FMASK)   ? {3'h0, fault_mask} :
        (req.addr == ADDR_FAULT)   ? {3'h0, fault_bits} :
        (req.addr == ADDR_FFLAG)   ? {3'h0, fault_now} :
        (req.addr == ADDR_SUPLVL)  ? {3'h0, input_supervisor_level} :
        (req.addr == ADDR_WARNLVL) ? {3'h0, input_low_warning} :
        (req.addr == ADDR_KEEP)    ? {3'h0, sleep_keep} :
        (req.addr == ADDR_MISC)    ? {6'h00, b2_sleep_sec, strap_pol} : 8'h00;

    // ----------------
    // Register writes
    // ----------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                cfg[i] <= '{RST_TRIG, RST_ON_DLY, RST_OFF_DLY, RST_SS, RST_VSET0};
            end
            for (int i = 0; i < NUM_BUCK; i++) begin
                vset1[i] <= RST_VSET1;
            end
            sleep_bit              <= 1'b0;
            off_cmd                <= 1'b0;
            scaling_select_field   <= 3'h0;
            fault_mask             <= RST_FMASK;
            input_supervisor_level <= RST_SUPLVL;
            input_low_warning      <= RST_WARNLVL;
            sleep_keep             <= RST_KEEP;
            strap_pol              <= 1'b0;
            b2_sleep_sec           <= 1'b0;
        end else if (req.wr) begin
            if (out_hit) begin
                unique case (out_fld)
                    FLD_TRIG:  cfg[out_idx].trig <= req.wdata[2:0];
                    FLD_DELAY: begin
                        cfg[out_idx].on_dly  <= req.wdata[3:0];
                        cfg[out_idx].off_dly <= req.wdata[7:4];
                    end
                    FLD_SS:    cfg[out_idx].ss <= req.wdata[1:0];
                    FLD_VSET:  cfg[out_idx].vset0 <= req.wdata;
                endcase
            end
            if (sec_hit) begin
                vset1[sec_off[1:0]] <= req.wdata;
            end
            if (req.addr == ADDR_CTRL) begin
                sleep_bit            <= req.wdata[CTRL_SLEEP];
                off_cmd              <= req.wdata[CTRL_OFF];
                scaling_select_field <= req.wdata[CTRL_SCAL_LO +: 3];
            end
            if (req.addr == ADDR_FMASK) begin
                fault_mask <= req.wdata[4:0];
            end
            if (req.addr == ADDR_SUPLVL) begin
                input_supervisor_level <= (wr_lvl > SUP_LVL_MAX) ? SUP_LVL_MAX : wr_lvl;
            end
            if (req.addr == ADDR_WARNLVL) begin
                input_low_warning <= (wr_lvl > WARN_LVL_MAX) ? WARN_LVL_MAX : wr_lvl;
            end
            if (req.addr == ADDR_KEEP) begin
                sleep_keep <= req.wdata[NUM_OUT-1:0];
            end
            if (req.addr == ADDR_MISC) begin
                strap_pol    <= req.wdata[MISC_STRAP_POL];
                b2_sleep_sec <= req.wdata[MISC_B2_SLP_SEC];
            end
        end
    end

    // ----------------
    // Status, interrupt and host pins
    // ----------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sup_latched      <= 1'b0;
            warn_latched     <= 1'b0;
            fault_bits       <= 5'h00;
            interrupt_out_n  <= 1'b1;
            supervisor_low_n <= 1'b1;
            warning_low_n    <= 1'b1;
            input_good_seen  <= 1'b0;
            dev_on           <= 1'b0;
            gpio_prev        <= 1'b0;
            buck2_secondary  <= 1'b0;
            reg_rdata        <= 8'h00;
        end else begin
            sup_latched      <= next_sup_latched;
            warn_latched     <= next_warn_latched;
            fault_bits       <= next_fault_bits;
            interrupt_out_n  <= next_irq_n;
            supervisor_low_n <= ~sup_below;
            warning_low_n    <= ~warn_below;
            input_good_seen  <= input_good_seen | ~sup_below;
            dev_on           <= next_dev_on;
            gpio_prev        <= power_on_gpio;
            buck2_secondary  <= next_b2_sec;
            reg_rdata        <= next_rdata;
        end
    end

    // ----------------
    // Per-output sequencers
    // ----------------
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        pmseq_state_type  state;
        pmseq_state_type  next_state;
        logic [CNT_W-1:0] cnt;
        wire logic        trig_ok = trig_active(cfg[i].trig, input_good_seen,
                                                power_good, seq_gpio);
        wire logic        want_on = dev_on & trig_ok & ~(low_power & ~sleep_keep[i]);
        wire logic [CNT_W-1:0] on_lim  = scaled(cfg[i].on_dly, DELAY_STEP);
        wire logic [CNT_W-1:0] off_lim = scaled(cfg[i].off_dly, DELAY_STEP);
        wire logic [CNT_W-1:0] ss_lim  = scaled({2'h0, cfg[i].ss} + 4'h1, SS_STEP);

        always_comb begin
            next_state = state;
            unique case (state)
                ST_OFF:      if (want_on) next_state = ST_ON_WAIT;
                ST_ON_WAIT:  if (!want_on) begin
                    next_state = ST_OFF;
                end else if (cnt >= on_lim) begin
                    next_state = ST_RAMP;
                end
                ST_RAMP:     if (!want_on) begin
                    next_state = ST_OFF_WAIT;
                end else if (cnt >= ss_lim) begin
                    next_state = ST_ON;
                end
                ST_ON:       if (!want_on) next_state = ST_OFF_WAIT;
                ST_OFF_WAIT: if (want_on) begin
                    next_state = ST_ON;
                end else if (cnt >= off_lim) begin
                    next_state = ST_OFF;
                end
                default:     next_state = ST_OFF;
            endcase
        end

        always_ff @(posedge clock) begin
            if (!resetn) begin
                state          <= ST_OFF;
                cnt            <= '0;
                out_enable[i]  <= 1'b0;
                out_ramping[i] <= 1'b0;
            end else begin
                state          <= next_state;
                cnt            <= (next_state != state) ? '0 : cnt + 1'b1;
                out_enable[i]  <= (next_state == ST_RAMP) || (next_state == ST_ON) ||
                                  (next_state == ST_OFF_WAIT);
                out_ramping[i] <= next_state == ST_RAMP;
            end
        end

        if (i < NUM_BUCK) begin : g_buck
            wire logic use_sec = (i == BUCK2_IDX) ? next_b2_sec : strap_sel[i];
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    strap_sel[i] <= 1'b0;
                    out_vset[i]  <= RST_VSET0;
                end else begin
                    if (state == ST_OFF) begin
                        strap_sel[i] <= strap_gpio ^ strap_pol;
                    end
                    out_vset[i] <= use_sec ? vset1[i] : cfg[i].vset0;
                end
            end
        end else begin : g_ldo
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    out_vset[i] <= RST_VSET0;
                end else begin
                    out_vset[i] <= cfg[i].vset0;
                end
            end
        end
    end

endmodule // pmseq_top

`default_nettype wire

// file: tb/pmseq_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pmseq_top_properties
    import pmseq_pkg::*;
#(
    parameter int DELAY_STEP = 4,
    parameter int SS_STEP    = 2
) (
    // Clock, reset and requests
    input wire logic                     clock,
    input wire logic                     resetn,
    input wire pmseq_req_type            req,
    input wire logic                     scaling_gpio,
    // Observed outputs
    input wire logic [NUM_OUT-1:0]       out_enable,
    input wire logic [NUM_OUT-1:0]       out_ramping,
    input wire logic [NUM_OUT-1:0][7:0]  out_vset,
    input wire logic                     buck2_secondary,
    input wire logic                     supervisor_low_n,
    input wire logic                     warning_low_n,
    input wire logic                     interrupt_out_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    int ramp_cnt;
    always_ff @(posedge clock) begin
        ramp_cnt <= out_ramping[0] ? ramp_cnt + 1 : 0;
    end
    rst_outputs_a: assert property (disable iff (1'b0)
        !resetn |=> (out_enable == '0) && interrupt_out_n) else $error("reset outputs");
    sup_irq_a: assert property ($fell(supervisor_low_n) |-> ##[0:2] !interrupt_out_n)
        else $error("supervisor irq missing");
    warn_irq_a: assert property ($fell(warning_low_n) |-> ##[0:2] !interrupt_out_n)
        else $error("warning irq missing");
    ramp_len_a: assert property ($fell(out_ramping[0]) |->
        ramp_cnt >= SS_STEP && ramp_cnt <= 4 * SS_STEP) else $error("ramp length");
    ramp_in_on_a: assert property ((out_ramping & ~out_enable) == '0)
        else $error("ramp without enable");
    on_starts_ramp_a: assert property ($rose(out_enable[0]) |-> out_ramping[0])
        else $error("enable without ramp");
    b2_gpio_sec_a: assert property (scaling_gpio |=> buck2_secondary)
        else $error("buck2 secondary missing");
    b1_vset_hold_a: assert property ((out_enable[0] && !req.wr) ##1
        (out_enable[0] && !req.wr) ##1 out_enable[0] |-> $stable(out_vset[0]))
        else $error("buck1 voltage moved");
    irq_release_a: assert property ($rose(interrupt_out_n) |->
        $past(req.rd) || $past(req.rd, 2)) else $error("irq released without read");
    start_c: cover property ($rose(out_enable[0]));
    irq_c: cover property ($fell(interrupt_out_n));
    b2_c: cover property ($rose(buck2_secondary));
endmodule // pmseq_top_properties
bind pmseq_top pmseq_top_properties #(.DELAY_STEP(DELAY_STEP), .SS_STEP(SS_STEP)) chk_u (
    .clock(clock), .resetn(resetn), .req(req), .scaling_gpio(scaling_gpio),
    .out_enable(out_enable), .out_ramping(out_ramping), .out_vset(out_vset),
    .buck2_secondary(buck2_secondary), .supervisor_low_n(supervisor_low_n),
    .warning_low_n(warning_low_n), .interrupt_out_n(interrupt_out_n));
`default_nettype wire

// file: tb/pmseq_regulator_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmseq_regulator_model
    import pmseq_pkg::*;
(
    // Clock and controls
    input  wire logic               clock,
    input  wire logic [NUM_OUT-1:0] out_enable,
    input  wire logic [NUM_OUT-1:0] out_ramping,
    // In-regulation flags
    output logic [NUM_OUT-1:0]      power_good
);
    // Regulation reached once the ramp is over
    always_ff @(posedge clock) begin
        power_good <= out_enable & ~out_ramping;
    end
endmodule // pmseq_regulator_model
`default_nettype wire

// file: tb/pmseq_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module pmseq_top_test;
    import pmseq_pkg::*;
    logic                    clock = 0, resetn = 0, scaling_gpio = 0, seq_gpio = 0;
    pmseq_req_type           req = '0;
    pmseq_fault_type         fault_cond = '0;
    logic [5:0]              vin_code = 6'h00;
    logic [7:0]              reg_rdata, d;
    logic [4:0]              v, power_good, out_enable, out_ramping;
    logic [NUM_OUT-1:0][7:0] out_vset;
    logic                    buck2_secondary, supervisor_low_n, warning_low_n, interrupt_out_n;
    logic                    strap_gpio = 0;
    logic [31:0]             seed = 32'h1B95;
    int                      err_count = 0, checks = 0, wn;
    always #10 clock = ~clock;
    pmseq_top #(.DELAY_STEP(4), .SS_STEP(2)) dut_u (.clock(clock), .resetn(resetn), .req(req),
        .reg_rdata(reg_rdata), .vin_code(vin_code), .power_good(power_good),
        .fault_cond(fault_cond), .power_on_gpio(1'b0), .seq_gpio(seq_gpio), .sleep_gpio(1'b0),
        .scaling_gpio(scaling_gpio), .strap_gpio(strap_gpio), .out_enable(out_enable),
        .out_ramping(out_ramping), .out_vset(out_vset), .buck2_secondary(buck2_secondary),
        .supervisor_low_n(supervisor_low_n), .warning_low_n(warning_low_n),
        .interrupt_out_n(interrupt_out_n));
    pmseq_regulator_model reg_u (.clock(clock), .out_enable(out_enable),
        .out_ramping(out_ramping), .power_good(power_good));
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] clampv(input logic [4:0] x, input logic [4:0] mx);
        return {3'h0, (x > mx) ? mx : x};
    endfunction
    task automatic summarize();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge clock) req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: x};
        @(posedge clock) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(posedge clock) req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clock) req.rd <= 1'b0;
        #1 x = reg_rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] x;
        rd(a, x);
        chk(x, exp);
    endtask
    task automatic wait_en(input logic [4:0] e);
        for (wn = 0; wn < 300 && out_enable !== e; wn++) cyc(1);
        if (wn == 300) begin
            err_count++;
            summarize();
        end else chk({3'h0, out_enable}, {3'h0, e});
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        err_count++;
        summarize();
    end
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        rchk(ADDR_SUPLVL, {3'h0, RST_SUPLVL});
        rchk(ADDR_FMASK, {3'h0, RST_FMASK});
        rchk(8'h50, 8'h00);
        for (int i = 0; i < NUM_OUT; i++) begin
            rchk(8'(ADDR_OUT_BASE + OUT_STRIDE * i + 3), RST_VSET0);
            rchk(8'(ADDR_OUT_BASE + OUT_STRIDE * i + 1), {RST_OFF_DLY, RST_ON_DLY});
        end
        chk({3'h0, out_enable}, 8'h00);
        chk({7'h0, supervisor_low_n}, 8'h00);
        rchk(ADDR_INMON, 8'h03);
        @(posedge clock) vin_code <= 6'h0A;
        wait_en(5'h1F);
        chk({7'h0, wn >= 4}, 8'h01);
        cyc(12);
        chk({3'h0, out_ramping}, 8'h00);
        @(posedge clock) vin_code <= 6'h00;
        cyc(10);
        chk({3'h0, out_enable}, 8'h1F);
        @(posedge clock) vin_code <= 6'h0A;
        cyc(3);
        rd(ADDR_INMON, d);
        rchk(ADDR_INMON, 8'h0C);
        $display("supervisor test done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 5'h1F : seed[4:0];
            wr(ADDR_SUPLVL, {3'h0, v});
            rchk(ADDR_SUPLVL, clampv(v, SUP_LVL_MAX));
            wr(ADDR_WARNLVL, {3'h0, v});
            rchk(ADDR_WARNLVL, clampv(v, WARN_LVL_MAX));
        end
        wr(ADDR_SUPLVL, 8'h03);
        cyc(3);
        chk({7'h0, warning_low_n}, {7'h0, 6'h0A >= clampv(v, WARN_LVL_MAX)});
        wr(ADDR_WARNLVL, {3'h0, RST_WARNLVL});
        cyc(3);
        rd(ADDR_INMON, d);
        rchk(ADDR_INMON, 8'h0C);
        $display("level test done");
        seed = lfsr(seed);
        @(posedge clock) fault_cond <= seed[4:0] | 5'h01;
        cyc(3);
        rchk(ADDR_FFLAG, {3'h0, seed[4:0] | 5'h01});
        chk({7'h0, interrupt_out_n}, 8'h01);
        wr(ADDR_FMASK, 8'h00);
        @(posedge clock) fault_cond <= '0;
        cyc(3);
        chk({7'h0, interrupt_out_n}, 8'h00);
        rd(ADDR_FAULT, d);
        cyc(3);
        chk({7'h0, interrupt_out_n}, 8'h01);
        $display("fault test done");
        @(posedge clock) scaling_gpio <= 1'b1;
        cyc(3);
        chk(out_vset[1], RST_VSET1);
        chk({3'h0, out_enable}, 8'h1F);
        @(posedge clock) scaling_gpio <= 1'b0;
        cyc(3);
        chk(out_vset[1], RST_VSET0);
        wr(8'h13, 8'h41);
        cyc(2);
        chk(out_vset[0], 8'h41);
        wr(ADDR_CTRL, 8'h10);
        cyc(3);
        chk({7'h0, buck2_secondary}, 8'h01);
        $display("scaling test done");
        wr(ADDR_CTRL, 8'h01);
        cyc(2);
        chk({3'h0, out_enable}, 8'h1F);
        wait_en(5'h00);
        wr(8'h1C, {5'h0, TRIG_GPIO});
        wr(8'h20, 8'h07);
        @(posedge clock) strap_gpio <= 1'b1;
        wr(ADDR_CTRL, 8'h00);
        wait_en(5'h07);
        @(posedge clock) strap_gpio <= 1'b0;
        cyc(20);
        chk(out_vset[0], RST_VSET1);
        chk({3'h0, out_enable}, 8'h07);
        @(posedge clock) seq_gpio <= 1'b1;
        wait_en(5'h0F);
        $display("sleep test done");
        summarize();
    end
endmodule // pmseq_top_test
`default_nettype wire
